//--- design/itcr_pkg.sv
/*
  Shared constants and types for the interval timer count readout block.
  Assumes byte-wide I/O ports decoded from an 8-bit port address.
*/
package itcr_pkg;
  localparam int unsigned NUM_CTR = 3;
  localparam logic [7:0] PORT_CTR0 = 8'h40;
  localparam logic [7:0] PORT_CTR1 = 8'h41;
  localparam logic [7:0] PORT_CTR2 = 8'h42;
  localparam logic [7:0] PORT_CTRL = 8'h43;
  // Control word fields
  localparam int unsigned SEL_HI = 7;
  localparam int unsigned SEL_LO = 6;
  localparam int unsigned RW_HI = 5;
  localparam int unsigned RW_LO = 4;
  localparam int unsigned MODE_HI = 3;
  localparam int unsigned MODE_LO = 1;
  localparam int unsigned BCD_BIT = 0;
  localparam int unsigned RB_NOCNT_BIT = 5;
  localparam int unsigned RB_NOSTS_BIT = 4;
  localparam int unsigned RB_SEL2_BIT = 3;
  localparam int unsigned RB_SEL1_BIT = 2;
  localparam int unsigned RB_SEL0_BIT = 1;
  localparam logic [1:0] SEL_READBACK = 2'b11;
  // Status byte fields
  localparam int unsigned STS_OUT_BIT = 7;
  localparam int unsigned STS_NULL_BIT = 6;
  localparam logic [7:0] STS_RESET = 8'h00;

  typedef enum logic [1:0] {
    ITCR_RW_LATCH = 2'b00,
    ITCR_RW_LSB = 2'b01,
    ITCR_RW_MSB = 2'b10,
    ITCR_RW_BOTH = 2'b11
  } itcr_rw_t;

  typedef struct packed {
    itcr_rw_t rw;
    logic [2:0] mode;
    logic bcd;
  } itcr_prog_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } itcr_io_t;
endpackage

//--- design/itcr_readout.sv
/*
  Count readout, latch, read-back and status path of a three-counter
  16-bit interval timer, plus count holding register loading.
  Assumes counting elements lie outside: they supply live counts, output
  levels and a load-done pulse, and take the holding register value.
  All inputs come from logic on clk_sys, so none is synchronised.
  Reads of the control port are not answered.
*/
// Behaviour
// - Read-back bit 2 selects counter 1, bit 1 counter 0; bit 0 reserved.
// - Count latch captures live count, read back via ports 40h, 41h, 42h.
// - Further count latch ignored while unread latched count is held.
// - Bits 7:6 select counter, 11 means read-back; bits 5:4 00 is latch.
// - Read-back with bit 4 low makes next data read return status.
// - Status bit 7 shows counter output level when status is latched.
// - Status bit 6 is one from count write until moved into counter.
// - Status bits 5:4 return programmed read/write access selection.
// - Status bits 3:1 return programmed counting mode code.
// - Status bit 0 reports binary or BCD countdown.
// - After reset status bit 7 reads zero; counter outputs start low.
// - Data port writes load 16-bit holding register in programmed order.
// - Data port reads return count or pending latched status byte.
// - Both latched: status first, then latched count, then live count.
// - Read-back: bit 5 low latches count, bit 4 low latches status.
module itcr_readout
  import itcr_pkg::*;
#(
  parameter int unsigned CNT_W = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Byte-wide I/O port access
  input wire itcr_io_t io,
  output logic [7:0] io_rdata,
  output logic io_rvalid,
  // Counting element side
  input wire logic [NUM_CTR-1:0][CNT_W-1:0] live_count,
  input wire logic [NUM_CTR-1:0] ctr_out,
  input wire logic [NUM_CTR-1:0] ce_loaded,
  output logic [NUM_CTR-1:0][CNT_W-1:0] hold_count,
  output logic [NUM_CTR-1:0] hold_written,
  output itcr_prog_t [NUM_CTR-1:0] prog
);

  logic ctrl_wr;
  logic [1:0] sel;
  logic [NUM_CTR-1:0] port_hit;
  logic [NUM_CTR-1:0] cnt_latch_req;
  logic [NUM_CTR-1:0] sts_latch_req;
  logic [NUM_CTR-1:0] prog_req;
  logic [NUM_CTR-1:0] rb_sel;

  // Per-counter access decode
  logic [NUM_CTR-1:0] wr_hit;
  logic [NUM_CTR-1:0] wr_lo;
  logic [NUM_CTR-1:0] wr_hi;
  logic [NUM_CTR-1:0] wr_full;
  logic [NUM_CTR-1:0] rd_hit;
  logic [NUM_CTR-1:0] rd_sts;
  logic [NUM_CTR-1:0] rd_hi;
  logic [NUM_CTR-1:0] rd_done;
  logic [NUM_CTR-1:0][CNT_W-1:0] rd_src;
  logic [NUM_CTR-1:0][7:0] rd_byte;
  logic [NUM_CTR-1:0][7:0] sts_now;

  itcr_prog_t [NUM_CTR-1:0] prog_q;
  logic [NUM_CTR-1:0][CNT_W-1:0] latch_q;
  logic [NUM_CTR-1:0] latched_q;
  logic [NUM_CTR-1:0] sts_pend_q;
  logic [NUM_CTR-1:0][7:0] sts_q;
  logic [NUM_CTR-1:0] rd_msb_q;
  logic [NUM_CTR-1:0] wr_msb_q;
  logic [NUM_CTR-1:0][CNT_W-1:0] hold_q;
  logic [NUM_CTR-1:0] hold_wr_q;
  logic [NUM_CTR-1:0] null_q;
  logic [7:0] rdata_q;
  logic rvalid_q;

  assign ctrl_wr = io.wr && (io.addr == PORT_CTRL);
  assign sel = io.wdata[SEL_HI:SEL_LO];
  assign port_hit[0] = io.addr == PORT_CTR0;
  assign port_hit[1] = io.addr == PORT_CTR1;
  assign port_hit[2] = io.addr == PORT_CTR2;
  assign rb_sel[0] = io.wdata[RB_SEL0_BIT];
  assign rb_sel[1] = io.wdata[RB_SEL1_BIT];
  // Read-back also reaches counter 2, through bit 3
  assign rb_sel[2] = io.wdata[RB_SEL2_BIT];

  always_comb begin
    cnt_latch_req = '0;
    sts_latch_req = '0;
    prog_req = '0;
    if (ctrl_wr) begin
      if (sel == SEL_READBACK) begin
        // Reserved bit 0 is not checked
        for (int i = 0; i < NUM_CTR; i++) begin
          cnt_latch_req[i] = rb_sel[i] && !io.wdata[RB_NOCNT_BIT];
          sts_latch_req[i] = rb_sel[i] && !io.wdata[RB_NOSTS_BIT];
        end
      end else if (io.wdata[RW_HI:RW_LO] == ITCR_RW_LATCH) begin
        cnt_latch_req[sel] = 1'b1;
      end else begin
        prog_req[sel] = 1'b1;
      end
    end
  end

  // Counter programming
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prog_q <= '0;
    end else begin
      for (int i = 0; i < NUM_CTR; i++) begin
        if (prog_req[i]) begin
          prog_q[i].rw <= itcr_rw_t'(io.wdata[RW_HI:RW_LO]);
          prog_q[i].mode <= io.wdata[MODE_HI:MODE_LO];
          prog_q[i].bcd <= io.wdata[BCD_BIT];
        end
      end
    end
  end

  // Which byte of the holding register a data-port write lands in
  always_comb begin
    for (int i = 0; i < NUM_CTR; i++) begin
      wr_hit[i] = io.wr && port_hit[i];
      wr_lo[i] = 1'b0;
      wr_hi[i] = 1'b0;
      if (wr_hit[i]) begin
        unique case (prog_q[i].rw)
          ITCR_RW_LSB: begin
            wr_lo[i] = 1'b1;
          end
          ITCR_RW_MSB: begin
            wr_hi[i] = 1'b1;
          end
          ITCR_RW_BOTH: begin
            wr_lo[i] = !wr_msb_q[i];
            wr_hi[i] = wr_msb_q[i];
          end
          ITCR_RW_LATCH: begin
            // No byte format programmed yet, so the write is dropped
          end
        endcase
      end
      wr_full[i] = wr_hi[i] || (wr_lo[i] && prog_q[i].rw == ITCR_RW_LSB);
    end
  end

  // Write byte pointer, restarted by every programming control word to the counter; a latch command leaves it
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_msb_q <= '0;
    end else begin
      for (int i = 0; i < NUM_CTR; i++) begin
        if (prog_req[i]) begin
          wr_msb_q[i] <= 1'b0;
        end else if (wr_hit[i] && prog_q[i].rw == ITCR_RW_BOTH) begin
          wr_msb_q[i] <= !wr_msb_q[i];
        end
      end
    end
  end

  // Holding register; a single-byte mode leaves the other byte as it was
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      hold_q <= '0;
      hold_wr_q <= '0;
    end else begin
      hold_wr_q <= wr_full;
      for (int i = 0; i < NUM_CTR; i++) begin
        if (wr_lo[i]) begin
          hold_q[i][7:0] <= io.wdata;
        end
        if (wr_hi[i]) begin
          hold_q[i][CNT_W-1:8] <= io.wdata;
        end
      end
    end
  end

  // Null count; a write in the same cycle as the load pulse wins
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      null_q <= '0;
    end else begin
      for (int i = 0; i < NUM_CTR; i++) begin
        if (prog_req[i] || wr_hit[i]) begin
          null_q[i] <= 1'b1;
        end else if (ce_loaded[i]) begin
          null_q[i] <= 1'b0;
        end
      end
    end
  end

  // Read decode per counter; a pending status byte always goes first
  always_comb begin
    for (int i = 0; i < NUM_CTR; i++) begin
      rd_hit[i] = io.rd && port_hit[i];
      rd_sts[i] = rd_hit[i] && sts_pend_q[i];
      rd_hi[i] = (prog_q[i].rw == ITCR_RW_MSB) ||
                 (prog_q[i].rw == ITCR_RW_BOTH && rd_msb_q[i]);
      // Last byte of the programmed format releases the latch
      rd_done[i] = rd_hit[i] && !sts_pend_q[i] &&
                   (prog_q[i].rw != ITCR_RW_BOTH || rd_msb_q[i]);
      rd_src[i] = latched_q[i] ? latch_q[i] : live_count[i];
      if (sts_pend_q[i]) begin
        rd_byte[i] = sts_q[i];
      end else if (rd_hi[i]) begin
        rd_byte[i] = rd_src[i][CNT_W-1:8];
      end else begin
        rd_byte[i] = rd_src[i][7:0];
      end
    end
  end

  // Read byte pointer; the status read does not move it
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rd_msb_q <= '0;
    end else begin
      for (int i = 0; i < NUM_CTR; i++) begin
        if (prog_req[i]) begin
          rd_msb_q[i] <= 1'b0;
        end else if (rd_hit[i] && !sts_pend_q[i]) begin
          rd_msb_q[i] <= prog_q[i].rw == ITCR_RW_BOTH && !rd_msb_q[i];
        end
      end
    end
  end

  // Count latch; the counting element runs on while it is frozen
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      latch_q <= '0;
      latched_q <= '0;
    end else begin
      for (int i = 0; i < NUM_CTR; i++) begin
        if (prog_req[i]) begin
          latched_q[i] <= 1'b0;
        end else if (cnt_latch_req[i] && !latched_q[i]) begin
          latch_q[i] <= live_count[i];
          latched_q[i] <= 1'b1;
        end else if (rd_done[i]) begin
          latched_q[i] <= 1'b0;
        end
      end
    end
  end

  // Status byte as it stands now; a read-back captures it
  always_comb begin
    for (int i = 0; i < NUM_CTR; i++) begin
      sts_now[i][STS_OUT_BIT] = ctr_out[i];
      sts_now[i][STS_NULL_BIT] = null_q[i];
      sts_now[i][RW_HI:RW_LO] = prog_q[i].rw;
      sts_now[i][MODE_HI:MODE_LO] = prog_q[i].mode;
      sts_now[i][BCD_BIT] = prog_q[i].bcd;
    end
  end

  // Status latch; a second request while one is pending is ignored
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sts_pend_q <= '0;
      sts_q <= {NUM_CTR{STS_RESET}};
    end else begin
      for (int i = 0; i < NUM_CTR; i++) begin
        if (sts_latch_req[i] && !sts_pend_q[i]) begin
          sts_pend_q[i] <= 1'b1;
          sts_q[i] <= sts_now[i];
        end else if (rd_sts[i]) begin
          sts_pend_q[i] <= 1'b0;
        end
      end
    end
  end

  // Read data holds until the next read
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdata_q <= '0;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= |rd_hit;
      for (int i = 0; i < NUM_CTR; i++) begin
        if (rd_hit[i]) begin
          rdata_q <= rd_byte[i];
        end
      end
    end
  end

  assign io_rdata = rdata_q;
  assign io_rvalid = rvalid_q;
  assign hold_count = hold_q;
  assign hold_written = hold_wr_q;
  assign prog = prog_q;

endmodule

//--- sim/itcr_readout_asserts.sv
/*
  Port checker for the interval timer count readout block.
  Assumes one clock domain and a bind onto every itcr_readout instance.
*/
module itcr_readout_asserts
  import itcr_pkg::*;
#(
  parameter int unsigned CNT_W = 16
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire itcr_io_t io,
  input wire logic [7:0] io_rdata,
  input wire logic io_rvalid,
  input wire logic [NUM_CTR-1:0][CNT_W-1:0] live_count,
  input wire logic [NUM_CTR-1:0] ctr_out,
  input wire logic [NUM_CTR-1:0] ce_loaded,
  input wire logic [NUM_CTR-1:0][CNT_W-1:0] hold_count,
  input wire logic [NUM_CTR-1:0] hold_written,
  input wire itcr_prog_t [NUM_CTR-1:0] prog
);
  timeunit 1ns;
  timeprecision 100ps;
  wire logic dat = io.addr[7:2] == 6'h10 && io.addr[1:0] != 2'h3;
  wire logic ctl = io.wr && io.addr == PORT_CTRL;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property p_rd_ans; io.rd && dat |=> io_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read unanswered");
  property p_no_ans; !(io.rd && dat) |=> !io_rvalid; endproperty
  a_no_ans: assert property (p_no_ans) else $error("stray read valid");
  property p_prog; ctl && io.wdata[7:4] == 4'h1 |=> prog[0] == $past(io.wdata[5:0]); endproperty
  a_prog: assert property (p_prog) else $error("control not kept");
  property p_cmd; ctl && io.wdata[5:4] == 2'h0 |=> prog == $past(prog); endproperty
  a_cmd: assert property (p_cmd) else $error("command changed control");
  property p_lsb;
    io.wr && io.addr == PORT_CTR0 && prog[0].rw == ITCR_RW_LSB
      |=> hold_written[0] && hold_count[0][7:0] == $past(io.wdata);
  endproperty
  a_lsb: assert property (p_lsb) else $error("low byte load wrong");
  property p_msb;
    io.wr && io.addr == PORT_CTR1 && prog[1].rw == ITCR_RW_MSB
      |=> hold_written[1] && hold_count[1][15:8] == $past(io.wdata);
  endproperty
  a_msb: assert property (p_msb) else $error("high byte load wrong");
  property p_no_load; !(io.wr && dat) |=> hold_written == '0; endproperty
  a_no_load: assert property (p_no_load) else $error("load without write");
  property p_rst; disable iff (1'b0) sys_rst |=> !io_rvalid && prog == '0; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule

bind itcr_readout itcr_readout_asserts #(.CNT_W(CNT_W)) u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .io(io), .io_rdata(io_rdata),
  .io_rvalid(io_rvalid), .live_count(live_count), .ctr_out(ctr_out),
  .ce_loaded(ce_loaded), .hold_count(hold_count), .hold_written(hold_written),
  .prog(prog));

//--- sim/itcr_readout_tb.sv
/*
  Self-checking bench for the interval timer count readout block.
  Assumes the bench stands in for software and the counting elements.
*/
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin miscompares++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module itcr_readout_tb
  import itcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 0;
  logic sys_rst = 1;
  itcr_io_t io = '0;
  logic [7:0] io_rdata, e;
  logic io_rvalid;
  logic [NUM_CTR-1:0][15:0] live_count = '0, hold_count;
  logic [NUM_CTR-1:0] ctr_out = '0, ce_loaded = '0, hold_written;
  itcr_prog_t [NUM_CTR-1:0] prog;
  logic [15:0] v;
  int miscompares = 0, comparisons = 0, c;
  always #4 clk_sys = ~clk_sys;
  itcr_readout uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .io(io), .io_rdata(io_rdata),
    .io_rvalid(io_rvalid), .live_count(live_count), .ctr_out(ctr_out),
    .ce_loaded(ce_loaded), .hold_count(hold_count), .hold_written(hold_written),
    .prog(prog));
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk_sys) #1 io = '{1'b1, 1'b0, a, x};
    @(posedge clk_sys) #1 io = '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic [7:0] m = 8'hFF);
    @(posedge clk_sys) #1 io = '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_sys) #1 io = '0;
    `CHK(io_rvalid, 1'b1)
    `CHK(io_rdata & m, x)
  endtask
  function automatic logic [7:0] sts(input logic o, input logic n, input logic [5:0] p);
    return {o, n, p};
  endfunction
  task automatic end_sim;
    $display("Counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #50000;
    miscompares++;
    end_sim();
  end
  initial begin
    void'($urandom(32'hC8B1009C));
    repeat (8) @(posedge clk_sys);
    #1 sys_rst = 0;
    wr(PORT_CTRL, 8'hE8);
    rd(PORT_CTR2, 8'h00, 8'h80);
    $display("Test reset done");
    wr(PORT_CTRL, 8'h34);
    wr(PORT_CTR0, 8'hCD);
    wr(PORT_CTR0, 8'hAB);
    `CHK(hold_count[0], 16'hABCD)
    v = 16'($urandom);
    live_count[0] = v;
    ctr_out[0] = 1'b1;
    wr(PORT_CTRL, 8'hC2);
    live_count[0] = ~v;
    rd(PORT_CTR0, sts(1'b1, 1'b1, 6'h34));
    rd(PORT_CTR0, v[7:0]);
    rd(PORT_CTR0, v[15:8]);
    rd(PORT_CTR0, ~v[7:0]);
    ctr_out[0] = 1'b0;
    @(posedge clk_sys) #1 ce_loaded[0] = 1'b1;
    @(posedge clk_sys) #1 ce_loaded[0] = 1'b0;
    wr(PORT_CTRL, 8'hE2);
    rd(PORT_CTR0, sts(1'b0, 1'b0, 6'h34));
    $display("Test read-back done");
    // Random control words, each followed by a byte load and a status read
    for (int i = 0; i < 16; i++) begin
      c = $urandom % 3;
      e = {c[1:0], 2'(1 + $urandom % 3), 3'($urandom % 6), 1'($urandom)};
      wr(PORT_CTRL, e);
      wr(8'(PORT_CTR0 + c), 8'($urandom));
      ctr_out[c] = 1'($urandom);
      wr(PORT_CTRL, 8'hE0 | 8'(8'h02 << c));
      rd(8'(PORT_CTR0 + c), sts(ctr_out[c], 1'b1, e[5:0]));
    end
    $display("Test status done");
    wr(PORT_CTRL, 8'h70);
    v = 16'($urandom);
    live_count[1] = v;
    wr(PORT_CTRL, 8'h40);
    live_count[1] = ~v;
    wr(PORT_CTRL, 8'h40);
    rd(PORT_CTR1, v[7:0]);
    wr(PORT_CTRL, 8'hB0);
    wr(PORT_CTR2, 8'h55);
    rd(PORT_CTR1, v[15:8]);
    wr(PORT_CTRL, 8'h40);
    rd(PORT_CTR1, ~v[7:0]);
    $display("Test count latch done");
    wr(PORT_CTRL, 8'h10);
    wr(PORT_CTR0, 8'h5A);
    `CHK(hold_count[0][7:0], 8'h5A)
    rd(PORT_CTR0, live_count[0][7:0]);
    wr(PORT_CTRL, 8'h60);
    wr(PORT_CTR1, 8'hA5);
    `CHK(hold_count[1][15:8], 8'hA5)
    rd(PORT_CTR1, live_count[1][15:8]);
    $display("Test single byte done");
    end_sim();
  end
endmodule
